// >>> src/port_ab_pkg.sv
// Constants, register map and carrier types for the port A and port B pin logic
//
// Summary of operation
// [R01] Segment field zero selects GPIO, else LCD common
// [R02] Port A pins float during reset
// [R03] Hold in sleep/watch, float in standby
// [R04] Port B is eight input-only pins
// [R05] Port B level register reads pins, ignores writes
// [R06] Pin selected as analog channel reads zero
// [R07] Function-select resets F7, only bit 3 writable
// [R08] Other function-select bits read one, unchangeable
// [R09] Direction bit one means output
// [R10] Port A read: latch if output, else pin
// [R11] Bit 3 routes pin 3 to interrupt/capture
// [R12] Subsleep holds pin state like sleep
package port_ab_pkg;

	// ****************************************
	// Register map: word indices; byte address is four times the index
	// ****************************************
	localparam logic [15:0] IDX_PORT_A_OUTPUT_LATCH  = 16'hFFDD;
	localparam logic [15:0] IDX_PORT_B_PIN_LEVEL     = 16'hFFDE;
	localparam logic [15:0] IDX_PORT_A_DIRECTION     = 16'hFFED;
	localparam logic [15:0] IDX_PORT_B_FUNC_SELECT   = 16'hFFEE;
	localparam logic [15:0] IDX_LCD_ADC_CONTROL      = 16'hFFF0;
	localparam logic [17:0] ADDR_PORT_A_OUTPUT_LATCH = {IDX_PORT_A_OUTPUT_LATCH, 2'h0};
	localparam logic [17:0] ADDR_PORT_B_PIN_LEVEL    = {IDX_PORT_B_PIN_LEVEL, 2'h0};
	localparam logic [17:0] ADDR_PORT_A_DIRECTION    = {IDX_PORT_A_DIRECTION, 2'h0};
	localparam logic [17:0] ADDR_PORT_B_FUNC_SELECT  = {IDX_PORT_B_FUNC_SELECT, 2'h0};
	localparam logic [17:0] ADDR_LCD_ADC_CONTROL     = {IDX_LCD_ADC_CONTROL, 2'h0};

	// ****************************************
	// Reset values and field layout
	// ****************************************
	localparam logic [7:0]  PORT_A_LATCH_RESET   = 8'hF0;
	localparam logic [7:0]  PORT_A_DIR_RESET     = 8'hF0;
	localparam logic [7:0]  PORT_A_UPPER_ONES    = 8'hF0;
	localparam logic [7:0]  DIR_READ_VALUE       = 8'hFF;
	localparam logic [7:0]  FUNC_SELECT_RESET    = 8'hF7;
	localparam logic [7:0]  FUNC_SELECT_FIXED    = 8'hF7;
	localparam int          PIN3_SELECT_BIT      = 3;
	localparam int          CTRL_SEGMENT_LSB     = 0;
	localparam int          CTRL_CHANNEL_LSB     = 4;
	localparam int          PORT_B_PINS          = 8;
	localparam logic [3:0]  SEGMENT_GPIO         = 4'h0;
	localparam logic [3:0]  SEGMENT_RESET        = 4'h0;
	localparam logic [3:0]  ADC_CHANNEL_RESET    = 4'h0;
	localparam logic [3:0]  ADC_CHANNEL_PB_BASE  = 4'h4;
	localparam logic [31:0] BUS_ERROR_DATA       = 32'h0000_0000;

	// ****************************************
	// Operating modes and carriers
	// ****************************************
	typedef enum logic [2:0] {
		MODE_ACTIVE,
		MODE_SUBACTIVE,
		MODE_SLEEP,
		MODE_SUBSLEEP,
		MODE_WATCH,
		MODE_STANDBY
	} op_mode_e;

	typedef struct packed {
		logic [3:0] level;
		logic [3:0] drive;
		logic [3:0] enable;
	} pin_drive_s;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [17:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

endpackage : port_ab_pkg

// >>> src/port_a_pin_stage.sv
// Port A pin stage: function select, direction and low-power pin states
module port_a_pin_stage
(
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire port_ab_pkg::op_mode_e       mode,
	input  wire logic [3:0]                  segment_select_field,
	input  wire logic [3:0]                  port_a_direction,
	input  wire logic [3:0]                  port_a_output_latch,
	input  wire logic [3:0]                  lcd_common_in,
	output port_ab_pkg::pin_drive_s          pins
);

	port_ab_pkg::pin_drive_s live;

	always_comb
	begin
		live.level = '0;
		live.drive = '0;
		live.enable = '0;
		// [R01] GPIO or LCD common
		if (segment_select_field == port_ab_pkg::SEGMENT_GPIO)
		begin
			// [R09] One drives the pin
			live.enable = port_a_direction;
			live.level  = port_a_output_latch;
		end
		else
		begin
			live.enable = '1;
			live.level  = lcd_common_in;
		end
		live.drive = live.level;
	end

	// Registered so the pin state can be frozen in low-power modes
	always_ff @(posedge clk)
	begin
		// [R02] Float in reset
		if (rst)
			pins <= '0;
		else
		begin
			case (mode)
				// [R03] Hold in sleep and watch
				port_ab_pkg::MODE_SLEEP,
				port_ab_pkg::MODE_WATCH:
					pins <= pins;
				// [R12] Subsleep holds too
				port_ab_pkg::MODE_SUBSLEEP:
					pins <= pins;
				// [R03] Standby floats
				port_ab_pkg::MODE_STANDBY:
					pins <= '0;
				default:
					pins <= live;
			endcase
		end
	end

endmodule : port_a_pin_stage

// >>> src/port_ab_top.sv
// Top of port A / port B pin logic with APB register slave
module port_ab_top
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [17:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire port_ab_pkg::op_mode_e mode,
	input  wire logic [3:0]            lcd_common_in,
	input  wire logic [3:0]            port_a_in,
	output logic      [3:0]            port_a_out,
	output logic      [3:0]            port_a_oe,
	input  wire logic [7:0]            port_b_in,
	output logic                       pin3_interrupt_select,
	output logic                       pin3_irq_capture_in,
	output logic      [7:0]            analog_inputs
);

	// ****************************************
	// Registers
	// ****************************************
	logic [3:0]              latch_reg;
	logic [3:0]              dir_reg;
	logic [3:0]              segment_reg;
	logic [3:0]              adc_channel_reg;
	logic                    pin3_sel_reg;
	logic [7:0]              pb_level;
	logic [7:0]              rd_next;
	logic                    err_next;
	logic                    wr_en;
	logic                    rd_setup;
	logic                    wr_latch;
	logic                    wr_dir;
	logic                    wr_ctrl;
	logic                    wr_fsel;
	port_ab_pkg::apb_req_s   req;
	port_ab_pkg::pin_drive_s pins;

	// ****************************************
	// Decode helpers
	// ****************************************
	// Full compare; a partial decode would alias the neighbouring port registers
	function automatic logic addr_is
	(
		input logic [17:0] addr,
		input logic [17:0] target
	);
		return addr == target;
	endfunction : addr_is

	// Channel codes below the port B base select no port B pin
	function automatic logic channel_hits
	(
		input logic [3:0] channel,
		input int         pin
	);
		return channel == port_ab_pkg::ADC_CHANNEL_PB_BASE + 4'(pin);
	endfunction : channel_hits

	// [R10] Latch for outputs, pin else
	function automatic logic [3:0] port_a_readback
	(
		input logic [3:0] dir,
		input logic [3:0] latch,
		input logic [3:0] pad
	);
		return (dir & latch) | (~dir & pad);
	endfunction : port_a_readback

	// ****************************************
	// Bus request and strobes
	// ****************************************
	assign req = '{
		psel:    psel,
		penable: penable,
		pwrite:  pwrite,
		paddr:   paddr,
		pwdata:  pwdata
	};

	// Writes land at the access edge; read data is captured at the setup edge
	assign wr_en    = req.psel && req.penable && req.pwrite;
	assign rd_setup = req.psel && !req.penable && !req.pwrite;
	assign pready   = 1'b1;

	assign wr_latch = wr_en && addr_is(req.paddr, port_ab_pkg::ADDR_PORT_A_OUTPUT_LATCH);
	assign wr_dir   = wr_en && addr_is(req.paddr, port_ab_pkg::ADDR_PORT_A_DIRECTION);
	assign wr_ctrl  = wr_en && addr_is(req.paddr, port_ab_pkg::ADDR_LCD_ADC_CONTROL);
	assign wr_fsel  = wr_en && addr_is(req.paddr, port_ab_pkg::ADDR_PORT_B_FUNC_SELECT);

	// ****************************************
	// Port A registers
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
			latch_reg <= port_ab_pkg::PORT_A_LATCH_RESET[3:0];
		else if (wr_latch)
			latch_reg <= req.pwdata[3:0];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			dir_reg <= port_ab_pkg::PORT_A_DIR_RESET[3:0];
		else if (wr_dir)
			dir_reg <= req.pwdata[3:0];
	end

	// ****************************************
	// Control register
	// ****************************************
	// Segment field and A/D channel share one control register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			segment_reg     <= port_ab_pkg::SEGMENT_RESET;
			adc_channel_reg <= port_ab_pkg::ADC_CHANNEL_RESET;
		end
		else if (wr_ctrl)
		begin
			segment_reg     <= req.pwdata[port_ab_pkg::CTRL_SEGMENT_LSB +: 4];
			adc_channel_reg <= req.pwdata[port_ab_pkg::CTRL_CHANNEL_LSB +: 4];
		end
	end

	// ****************************************
	// Port B function select
	// ****************************************
	always_ff @(posedge clk)
	begin
		// [R07] Only bit 3 writable
		if (rst)
			pin3_sel_reg <= port_ab_pkg::FUNC_SELECT_RESET[port_ab_pkg::PIN3_SELECT_BIT];
		else if (wr_fsel)
			pin3_sel_reg <= req.pwdata[port_ab_pkg::PIN3_SELECT_BIT];
	end

	// ****************************************
	// Port B input path
	// ****************************************
	// [R04] Input only, no latch
	// [R06] Analog channel reads zero
	genvar gi;
	generate
		for (gi = 0; gi < port_ab_pkg::PORT_B_PINS; gi++)
		begin : g_pb
			assign pb_level[gi]      = channel_hits(adc_channel_reg, gi) ? 1'b0 : port_b_in[gi];
			assign analog_inputs[gi] = port_b_in[gi];
		end
	endgenerate

	// [R11] Pin 3 routing
	assign pin3_interrupt_select = pin3_sel_reg;
	assign pin3_irq_capture_in   = pin3_sel_reg & port_b_in[port_ab_pkg::PIN3_SELECT_BIT];

	// ****************************************
	// Read decode
	// ****************************************
	always_comb
	begin
		rd_next  = '0;
		err_next = 1'b0;
		// [R10] Latch for outputs, pin else
		if (addr_is(req.paddr, port_ab_pkg::ADDR_PORT_A_OUTPUT_LATCH))
			rd_next = port_ab_pkg::PORT_A_UPPER_ONES
				| {4'h0, port_a_readback(dir_reg, latch_reg, port_a_in)};
		// Direction register is write-only
		else if (addr_is(req.paddr, port_ab_pkg::ADDR_PORT_A_DIRECTION))
			rd_next = port_ab_pkg::DIR_READ_VALUE;
		// [R05] Pin levels, writes ignored
		else if (addr_is(req.paddr, port_ab_pkg::ADDR_PORT_B_PIN_LEVEL))
			rd_next = pb_level;
		// [R08] Reserved bits read one
		else if (addr_is(req.paddr, port_ab_pkg::ADDR_PORT_B_FUNC_SELECT))
			rd_next = port_ab_pkg::FUNC_SELECT_FIXED
				| ({7'h00, pin3_sel_reg} << port_ab_pkg::PIN3_SELECT_BIT);
		else if (addr_is(req.paddr, port_ab_pkg::ADDR_LCD_ADC_CONTROL))
			rd_next = {adc_channel_reg, segment_reg};
		else
			err_next = 1'b1;
	end

	// ****************************************
	// Read data and error response
	// ****************************************
	// Loaded at the setup edge so it stands through the whole access phase
	always_ff @(posedge clk)
	begin
		if (rst)
			prdata <= port_ab_pkg::BUS_ERROR_DATA;
		else if (rd_setup)
			prdata <= {24'h000000, rd_next};
	end

	assign pslverr = req.psel && req.penable && err_next;

	// ****************************************
	// Port A pin stage
	// ****************************************
	port_a_pin_stage u_pin_stage
	(
		.clk                  (clk),
		.rst                  (rst),
		.mode                 (mode),
		.segment_select_field (segment_reg),
		.port_a_direction     (dir_reg),
		.port_a_output_latch  (latch_reg),
		.lcd_common_in        (lcd_common_in),
		.pins                 (pins)
	);

	assign port_a_out = pins.level;
	assign port_a_oe  = pins.enable;

endmodule : port_ab_top

// >>> tb/port_ab_assertions.sv
// Assertions on the ports of the port A / port B pin logic
module port_ab_checker
(
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [17:0]           paddr,
	input wire logic [31:0]           prdata,
	input wire port_ab_pkg::op_mode_e mode,
	input wire logic [3:0]            port_a_out,
	input wire logic [3:0]            port_a_oe,
	input wire logic [7:0]            port_b_in,
	input wire logic                  pin3_interrupt_select,
	input wire logic                  pin3_irq_capture_in
);
	// ***
	// Pin float and hold states, register read values and pin 3 routing
	// ***
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire rd = psel && penable && !pwrite;
	wire sby = mode == port_ab_pkg::MODE_STANDBY;
	wire sub = mode == port_ab_pkg::MODE_SUBSLEEP;
	wire hold = mode == port_ab_pkg::MODE_SLEEP || mode == port_ab_pkg::MODE_WATCH;
	a_reset_float: assert property (disable iff (1'b0) rst |=> port_a_oe == 4'h0)
		else $error("port A driven in reset");
	a_standby_float: assert property (sby |=> {port_a_oe, port_a_out} == 8'h0)
		else $error("port A driven in standby");
	a_sleep_hold: assert property (hold |=> $stable(port_a_oe) && $stable(port_a_out))
		else $error("port A changed in sleep or watch");
	a_subsleep_hold: assert property (sub |=> $stable({port_a_oe, port_a_out}))
		else $error("port A changed in subsleep");
	a_fsel_read: assert property (
		rd && paddr == port_ab_pkg::ADDR_PORT_B_FUNC_SELECT |-> (prdata | 32'h8) == 32'hFF)
		else $error("function select read wrong");
	a_dir_read: assert property (
		rd && paddr == port_ab_pkg::ADDR_PORT_A_DIRECTION |-> prdata == 32'hFF)
		else $error("direction read not all ones");
	a_latch_read: assert property (
		rd && paddr == port_ab_pkg::ADDR_PORT_A_OUTPUT_LATCH |-> prdata[31:4] == 28'hF)
		else $error("port A upper bits wrong");
	a_level_read: assert property (
		rd && paddr == port_ab_pkg::ADDR_PORT_B_PIN_LEVEL |-> prdata[31:8] == 24'h0
		&& (prdata[7:0] & ~$past(port_b_in)) == 8'h0)
		else $error("port B level read wrong");
	a_pin3_route: assert property (
		pin3_irq_capture_in == (pin3_interrupt_select & port_b_in[3]))
		else $error("pin 3 routing wrong");
	cover property (rd && paddr == 16'hFFEE);
	cover property (sby ##1 !sby);
	cover property (hold ##1 hold);
endmodule : port_ab_checker

bind port_ab_top port_ab_checker chk
(
	.clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .mode,
	.port_a_out, .port_a_oe, .port_b_in, .pin3_interrupt_select, .pin3_irq_capture_in
);

// >>> tb/port_pins_model.sv
// Pad model for the port A pins and their external source
module port_pins_model
(
	input  wire logic [3:0] port_a_out,
	input  wire logic [3:0] port_a_oe,
	input  wire logic [3:0] ext_level,
	output logic      [3:0] port_a_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Device drive wins; a floating pin follows the outside source
	assign port_a_in = (port_a_out & port_a_oe) | (ext_level & ~port_a_oe);
endmodule : port_pins_model

// >>> tb/test_port_ab_top.sv
// Self-checking bench of the port A / port B pin logic
module test_port_ab_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, p3sel, p3cap, err;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] lcd, ext, pa_in, pa_out, pa_oe;
	logic [7:0] pb, an;
	localparam logic [17:0] A_LATCH = port_ab_pkg::ADDR_PORT_A_OUTPUT_LATCH;
	localparam logic [17:0] A_LEVEL = port_ab_pkg::ADDR_PORT_B_PIN_LEVEL;
	localparam logic [17:0] A_DIR   = port_ab_pkg::ADDR_PORT_A_DIRECTION;
	localparam logic [17:0] A_FSEL  = port_ab_pkg::ADDR_PORT_B_FUNC_SELECT;
	localparam logic [17:0] A_CTRL  = port_ab_pkg::ADDR_LCD_ADC_CONTROL;
	port_ab_pkg::op_mode_e mode;
	int miscompares, check_count, cycles;

	port_ab_top uut
	(
		.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.mode, .lcd_common_in(lcd), .port_a_in(pa_in), .port_a_out(pa_out),
		.port_a_oe(pa_oe), .port_b_in(pb), .pin3_interrupt_select(p3sel),
		.pin3_irq_capture_in(p3cap), .analog_inputs(an)
	);
	port_pins_model pins
	(
		.port_a_out(pa_out), .port_a_oe(pa_oe), .ext_level(ext), .port_a_in(pa_in)
	);

	task automatic conclude();
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; read data and error are taken at the edge that ends it
	task automatic access(input logic wr, input logic [17:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : access

	task automatic rchk(input logic [17:0] a, input logic [31:0] e);
		access(1'b0, a, 32'h0);
		check(rd, e);
	endtask : rchk

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Far above the roughly 120 cycles the sequence needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			conclude();
		end
	end

	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		mode = port_ab_pkg::MODE_ACTIVE;
		lcd = 4'h6;
		ext = 4'hA;
		pb = 8'hA5;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rchk(A_FSEL, 32'hF7);
		access(1'b1, A_LEVEL, 32'h0);
		rchk(A_LEVEL, 32'hA5);
		check(an, 8'hA5);
		access(1'b1, A_FSEL, 32'h0);
		rchk(A_FSEL, 32'hF7);
		access(1'b1, A_FSEL, 32'h8);
		rchk(A_FSEL, 32'hFF);
		check(p3sel, 1'b1);
		pb <= 8'hFF;
		@(posedge clk);
		check(p3cap, 1'b1);
		for (int c = 3; c < 12; c++)
		begin
			access(1'b1, A_CTRL, c << 4);
			rchk(A_LEVEL, 32'hFF & ~((32'h1 << c) >> 4));
		end
		access(1'b1, A_CTRL, 32'h0);
		access(1'b1, A_DIR, 32'h5);
		access(1'b1, A_LATCH, 32'h3);
		rchk(A_LATCH, 32'hFB);
		check(pa_oe, 4'h5);
		check(pa_out & pa_oe, 4'h1);
		mode <= port_ab_pkg::MODE_SLEEP;
		access(1'b1, A_DIR, 32'hF);
		check(pa_oe, 4'h5);
		mode <= port_ab_pkg::MODE_SUBSLEEP;
		access(1'b1, A_LATCH, 32'h0);
		check(pa_out & pa_oe, 4'h1);
		mode <= port_ab_pkg::MODE_WATCH;
		access(1'b1, A_DIR, 32'h0);
		check(pa_oe, 4'h5);
		mode <= port_ab_pkg::MODE_STANDBY;
		repeat (2) @(posedge clk);
		check(pa_oe, 4'h0);
		mode <= port_ab_pkg::MODE_SUBACTIVE;
		access(1'b1, A_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		check(pa_oe, 4'hF);
		check(pa_out, 4'h6);
		access(1'b0, 18'h3FF00, 32'h0);
		check(err, 1'b1);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		check(pa_oe, 4'h0);
		rst <= 1'b0;
		rchk(A_FSEL, 32'hF7);
		conclude();
	end
endmodule : test_port_ab_top
